//--- verilog/cctr_pkg.sv
// constants and types shared by the converter core trim register bank
package cctr_pkg;

	// ---------------------------------------------------------------
	// register indices (byte address is four times the index)
	// ---------------------------------------------------------------
	localparam logic [11:0] IDX_OFFSET_TRIM_CORE3_INPUT_C = 12'h338;
	localparam logic [11:0] IDX_OFFSET_TRIM_CORE3_INPUT_D = 12'h33A;
	localparam logic [11:0] IDX_OFFSET_TRIM_CORE4         = 12'h33C;
	localparam logic [11:0] IDX_OFFSET_TRIM_CORE5         = 12'h33E;
	localparam logic [11:0] IDX_GAIN_TRIM_CORE0           = 12'h360;
	localparam logic [11:0] IDX_GAIN_TRIM_CORE1           = 12'h361;
	localparam logic [11:0] IDX_GAIN_TRIM_CORE2_INPUT_A   = 12'h362;
	localparam int unsigned ADDR_W                        = 14;

	// ---------------------------------------------------------------
	// storage slots, also the fuse word addresses
	// ---------------------------------------------------------------
	localparam int unsigned NREG       = 7;
	localparam logic [2:0]  SLOT_OFFSET_C3C = 3'h0;
	localparam logic [2:0]  SLOT_OFFSET_C3D = 3'h1;
	localparam logic [2:0]  SLOT_OFFSET_C4  = 3'h2;
	localparam logic [2:0]  SLOT_OFFSET_C5  = 3'h3;
	localparam logic [2:0]  SLOT_GAIN_C0    = 3'h4;
	localparam logic [2:0]  SLOT_GAIN_C1    = 3'h5;
	localparam logic [2:0]  SLOT_GAIN2      = 3'h6;
	localparam logic [2:0]  SLOT_LAST       = 3'h6;

	// ---------------------------------------------------------------
	// field layout and reset values
	// ---------------------------------------------------------------
	localparam logic [15:0] OFS_REG_MASK    = 16'hFFFF;
	localparam logic [15:0] GAIN_REG_MASK   = 16'h00FF;
	localparam logic [15:0] OFS_FIELD_MASK  = 16'h0FFF;
	localparam logic [15:0] GAIN_FIELD_MASK = 16'h001F;
	localparam logic [15:0] RST_VAL         = 16'h0000;
	localparam logic [11:0] SAT_MAX         = 12'hFFF;
	localparam int unsigned GAIN_SHIFT      = 9;

	// ---------------------------------------------------------------
	// state encodings
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		CCTR_ST_LOAD = 2'b01,
		CCTR_ST_RUN  = 2'b10
	} cctr_state_t;

	typedef enum logic [1:0] {
		CCTR_LD_REQ  = 2'b01,
		CCTR_LD_DONE = 2'b10
	} cctr_ld_state_t;

endpackage

//--- verilog/cctr_fuse_loader.sv
// walks the fuse memory once after reset and hands each trim word over
`timescale 1ns/1ns
module cctr_fuse_loader (
	input  wire logic        clk_sys_i,
	input  wire logic        rstn_i,
	output wire logic        fuse_req_o,
	output wire logic [2:0]  fuse_addr_o,
	input  wire logic [11:0] fuse_data_i,
	input  wire logic        fuse_ack_i,
	output wire logic        ld_we_o,
	output wire logic [2:0]  ld_idx_o,
	output wire logic [11:0] ld_data_o,
	output wire logic        ld_done_o
);
	import cctr_pkg::*;

	typedef struct packed {
		cctr_ld_state_t st;
		logic [2:0]     slot;
		logic           we;
		logic [2:0]     idx;
		logic [11:0]    data;
	} cctr_ld_q_t;

	cctr_ld_q_t q;
	cctr_ld_q_t d;

	// ---------------------------------------------------------------
	// sequencing
	// ---------------------------------------------------------------
	always_comb begin
		d    = q;
		d.we = 1'b0;
		case (q.st)
			CCTR_LD_REQ: begin
				if (fuse_ack_i) begin
					d.we   = 1'b1;
					d.idx  = q.slot;
					d.data = fuse_data_i;
					if (q.slot == SLOT_LAST) begin
						d.st = CCTR_LD_DONE;
					end else begin
						d.slot = q.slot + 3'h1;
					end
				end
			end
			CCTR_LD_DONE: begin
			end
			default: begin
				d.st = CCTR_LD_REQ;
			end
		endcase
	end

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			q <= '{st: CCTR_LD_REQ, default: '0};
		end else begin
			q <= d;
		end
	end

	assign fuse_req_o  = (q.st == CCTR_LD_REQ);
	assign fuse_addr_o = q.slot;
	assign ld_we_o     = q.we;
	assign ld_idx_o    = q.idx;
	assign ld_data_o   = q.data;
	assign ld_done_o   = (q.st == CCTR_LD_DONE);

endmodule

//--- verilog/cctr_trim_regs.sv
// converter core trim register bank with apb access and trim data paths
// Functional notes
// RULE_01: core three input C uses its offset
// RULE_02: core three input D uses separate offset
// RULE_03: core four offset applied to every conversion
// RULE_04: core five offset applied to every conversion
// RULE_05: core zero scaled by its fine gain
// RULE_06: core one scaled by its fine gain
// RULE_07: trim fields load factory fuse values at start
// RULE_08: software writes zero to reserved bits
// RULE_09: core two input A gain own address
// RULE_10: offset trim values are unsigned
// RULE_11: software avoids offsets during offset calibration
// RULE_12: reads return last written or fuse value
// RULE_13: new trim values act without reset
`timescale 1ns/1ns
module cctr_trim_regs (
	input  wire logic                        clk_sys_i,
	input  wire logic                        rstn_i,
	input  wire logic [cctr_pkg::ADDR_W-1:0] paddr_i,
	input  wire logic                        psel_i,
	input  wire logic                        penable_i,
	input  wire logic                        pwrite_i,
	input  wire logic [31:0]                 pwdata_i,
	output wire logic [31:0]                 prdata_o,
	output wire logic                        pready_o,
	output wire logic                        pslverr_o,
	output wire logic                        fuse_req_o,
	output wire logic [2:0]                  fuse_addr_o,
	input  wire logic [11:0]                 fuse_data_i,
	input  wire logic                        fuse_ack_i,
	input  wire logic [11:0]                 core0_data_i,
	input  wire logic                        core0_vld_i,
	input  wire logic [11:0]                 core1_data_i,
	input  wire logic                        core1_vld_i,
	input  wire logic [11:0]                 core2a_data_i,
	input  wire logic                        core2a_vld_i,
	input  wire logic [11:0]                 core3_data_i,
	input  wire logic                        core3_vld_i,
	input  wire logic                        core3_sel_d_i,
	input  wire logic [11:0]                 core4_data_i,
	input  wire logic                        core4_vld_i,
	input  wire logic [11:0]                 core5_data_i,
	input  wire logic                        core5_vld_i,
	output wire logic [11:0]                 core0_data_o,
	output wire logic                        core0_vld_o,
	output wire logic [11:0]                 core1_data_o,
	output wire logic                        core1_vld_o,
	output wire logic [11:0]                 core2a_data_o,
	output wire logic                        core2a_vld_o,
	output wire logic [11:0]                 core3_data_o,
	output wire logic                        core3_vld_o,
	output wire logic [11:0]                 core4_data_o,
	output wire logic                        core4_vld_o,
	output wire logic [11:0]                 core5_data_o,
	output wire logic                        core5_vld_o
);
	import cctr_pkg::*;

	typedef struct packed {
		cctr_state_t      st;
		logic [6:0][15:0] regs;
		logic [31:0]      rdata;
		logic             slverr;
		logic [5:0][11:0] dat;
		logic [5:0]       vld;
	} cctr_core_q_t;

	cctr_core_q_t q;
	cctr_core_q_t d;

	logic             ld_we;
	logic [2:0]       ld_idx;
	logic [11:0]      ld_data;
	logic             ld_done;
	logic [3:0]       dec;
	logic             hit;
	logic [2:0]       slot;
	logic             pready;
	logic             wr_acc;
	logic [5:0][11:0] din;
	logic [5:0]       vin;
	logic [5:3][11:0] ofs;
	logic [2:0][4:0]  gain;
	logic [5:0][12:0] sum;
	logic [5:0][11:0] res;

	// ---------------------------------------------------------------
	// address decode
	// ---------------------------------------------------------------
	function automatic logic [3:0] cctr_decode(input logic [ADDR_W-1:0] a);
		logic [3:0] r;
		r = 4'h0;
		if (a[1:0] == 2'h0) begin
			case (a[ADDR_W-1:2])
				IDX_OFFSET_TRIM_CORE3_INPUT_C: r = {1'b1, SLOT_OFFSET_C3C};
				IDX_OFFSET_TRIM_CORE3_INPUT_D: r = {1'b1, SLOT_OFFSET_C3D};
				IDX_OFFSET_TRIM_CORE4:         r = {1'b1, SLOT_OFFSET_C4};
				IDX_OFFSET_TRIM_CORE5:         r = {1'b1, SLOT_OFFSET_C5};
				IDX_GAIN_TRIM_CORE0:           r = {1'b1, SLOT_GAIN_C0};
				IDX_GAIN_TRIM_CORE1:           r = {1'b1, SLOT_GAIN_C1};
				IDX_GAIN_TRIM_CORE2_INPUT_A:   r = {1'b1, SLOT_GAIN2}; // [RULE_09]
				default:                       r = 4'h0;
			endcase
		end
		return r;
	endfunction

	function automatic logic [15:0] cctr_reg_mask(input logic [2:0] s);
		return (s < SLOT_GAIN_C0) ? OFS_REG_MASK : GAIN_REG_MASK;
	endfunction

	function automatic logic [15:0] cctr_field_mask(input logic [2:0] s);
		return (s < SLOT_GAIN_C0) ? OFS_FIELD_MASK : GAIN_FIELD_MASK;
	endfunction

	assign dec    = cctr_decode(paddr_i);
	assign hit    = dec[3];
	assign slot   = dec[2:0];
	// bus stalls until every fuse value is in place
	assign pready = (q.st == CCTR_ST_RUN);
	assign wr_acc = psel_i && penable_i && pready && pwrite_i && hit;

	// ---------------------------------------------------------------
	// fuse load
	// ---------------------------------------------------------------
	cctr_fuse_loader cctr_fuse_loader_i (
		.clk_sys_i   (clk_sys_i),
		.rstn_i      (rstn_i),
		.fuse_req_o  (fuse_req_o),
		.fuse_addr_o (fuse_addr_o),
		.fuse_data_i (fuse_data_i),
		.fuse_ack_i  (fuse_ack_i),
		.ld_we_o     (ld_we),
		.ld_idx_o    (ld_idx),
		.ld_data_o   (ld_data),
		.ld_done_o   (ld_done)
	);

	// ---------------------------------------------------------------
	// trim data paths
	// ---------------------------------------------------------------
	assign din[0] = core0_data_i;
	assign din[1] = core1_data_i;
	assign din[2] = core2a_data_i;
	assign din[3] = core3_data_i;
	assign din[4] = core4_data_i;
	assign din[5] = core5_data_i;
	assign vin[0] = core0_vld_i;
	assign vin[1] = core1_vld_i;
	assign vin[2] = core2a_vld_i;
	assign vin[3] = core3_vld_i;
	assign vin[4] = core4_vld_i;
	assign vin[5] = core5_vld_i;

	// core three picks its offset by the input it is sampling
	assign ofs[3] = core3_sel_d_i ? q.regs[SLOT_OFFSET_C3D][11:0] : q.regs[SLOT_OFFSET_C3C][11:0]; // [RULE_01] [RULE_02]
	assign ofs[4] = q.regs[SLOT_OFFSET_C4][11:0]; // [RULE_03]
	assign ofs[5] = q.regs[SLOT_OFFSET_C5][11:0]; // [RULE_04]
	assign gain[0] = q.regs[SLOT_GAIN_C0][4:0]; // [RULE_05]
	assign gain[1] = q.regs[SLOT_GAIN_C1][4:0]; // [RULE_06]
	assign gain[2] = q.regs[SLOT_GAIN2][4:0];

	for (genvar k = 0; k < 6; k++) begin : g_path
		if (k < 3) begin : g_gain
			logic [16:0] prod;
			// fine gain adds up to 31/512 of the sample
			assign prod   = {5'h0, din[k]} * {12'h0, gain[k]};
			assign sum[k] = {1'b0, din[k]} + 13'(prod >> GAIN_SHIFT);
		end else begin : g_ofs
			// zero extension: offset counts upward only
			assign sum[k] = {1'b0, din[k]} + {1'b0, ofs[k]}; // [RULE_10]
		end
		// saturate rather than wrap, a wrap would flip full scale to zero
		assign res[k] = sum[k][12] ? SAT_MAX : sum[k][11:0];
	end

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb begin
		d = q;
		if (ld_we) begin
			d.regs[ld_idx] = {4'h0, ld_data} & cctr_field_mask(ld_idx); // [RULE_07]
		end
		if (wr_acc) begin
			// offset reserved bits and gain bits 7:5 are stored as written and read back, gain bits 15:8 are dropped
			d.regs[slot] = pwdata_i[15:0] & cctr_reg_mask(slot); // [RULE_12] [RULE_13]
		end
		case (q.st)
			CCTR_ST_LOAD: begin
				if (ld_done && !ld_we) begin
					d.st = CCTR_ST_RUN;
				end
			end
			CCTR_ST_RUN: begin
			end
			default: begin
				d.st = CCTR_ST_LOAD;
			end
		endcase
		// read data refreshes until the access is accepted
		if (psel_i && !(penable_i && pready)) begin
			d.rdata  = hit ? {16'h0, q.regs[slot]} : 32'h0; // [RULE_12]
			d.slverr = !hit;
		end
		d.dat = res;
		d.vld = vin;
	end

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			q <= '{st: CCTR_ST_LOAD, default: '0};
		end else begin
			q <= d;
		end
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	assign prdata_o      = q.rdata;
	assign pready_o      = pready;
	assign pslverr_o     = q.slverr;
	assign core0_data_o  = q.dat[0];
	assign core1_data_o  = q.dat[1];
	assign core2a_data_o = q.dat[2];
	assign core3_data_o  = q.dat[3];
	assign core4_data_o  = q.dat[4];
	assign core5_data_o  = q.dat[5];
	assign core0_vld_o   = q.vld[0];
	assign core1_vld_o   = q.vld[1];
	assign core2a_vld_o  = q.vld[2];
	assign core3_vld_o   = q.vld[3];
	assign core4_vld_o   = q.vld[4];
	assign core5_vld_o   = q.vld[5];

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!rstn_i);

	property p_ofs(v, logic [11:0] x, logic [11:0] o, logic [11:0] y);
		v |=> ((({1'b0, $past(x)} + {1'b0, $past(o)}) > 13'h0FFF) ? (y == SAT_MAX) : (y == $past(x) + $past(o)));
	endproperty

	property p_gain(v, logic [11:0] x, logic [4:0] g, logic [11:0] y);
		v |=> (($past(g) == 5'h0) ? (y == $past(x)) : (y >= $past(x) && y - $past(x) <= ($past(x) >> 4)));
	endproperty

	sequence s_wr;
		psel_i && penable_i && pready_o && pwrite_i && !pslverr_o;
	endsequence

	sequence s_setup_g2a;
		psel_i && !penable_i && (paddr_i == {IDX_GAIN_TRIM_CORE2_INPUT_A, 2'h0});
	endsequence

	AST_OFFSET_C3C: assert property (p_ofs(core3_vld_i && !core3_sel_d_i, core3_data_i, q.regs[SLOT_OFFSET_C3C][11:0], core3_data_o)) // [RULE_01]
		else $error("core three input C offset wrong");
	AST_OFFSET_C3D: assert property (p_ofs(core3_vld_i && core3_sel_d_i, core3_data_i, q.regs[SLOT_OFFSET_C3D][11:0], core3_data_o)) // [RULE_02]
		else $error("core three input D offset wrong");
	AST_OFFSET_C4: assert property (p_ofs(core4_vld_i, core4_data_i, q.regs[SLOT_OFFSET_C4][11:0], core4_data_o)) // [RULE_03]
		else $error("core four offset wrong");
	AST_OFFSET_C5: assert property (p_ofs(core5_vld_i, core5_data_i, q.regs[SLOT_OFFSET_C5][11:0], core5_data_o)) // [RULE_04]
		else $error("core five offset wrong");
	AST_GAIN_C0: assert property (p_gain(core0_vld_i, core0_data_i, q.regs[SLOT_GAIN_C0][4:0], core0_data_o)) // [RULE_05]
		else $error("core zero gain wrong");
	AST_GAIN_C1: assert property (p_gain(core1_vld_i, core1_data_i, q.regs[SLOT_GAIN_C1][4:0], core1_data_o)) // [RULE_06]
		else $error("core one gain wrong");
	AST_FUSE: assert property (ld_we |=> q.regs[$past(ld_idx)][11:0] == ($past(ld_data) & cctr_field_mask($past(ld_idx)))) // [RULE_07]
		else $error("fuse value not loaded");
	AST_GAIN_TRIM_CORE2_INPUT_A_ADDR: assert property (s_setup_g2a ##1 (penable_i && pready_o) |-> !pslverr_o) // [RULE_09]
		else $error("core two input A gain not decoded");
	AST_RDBACK: assert property (psel_i && penable_i && pready_o && !pwrite_i && hit |-> prdata_o == {16'h0, q.regs[slot]}) // [RULE_12]
		else $error("read data differs from stored value");
	AST_LIVE: assert property (s_wr |=> q.regs[$past(slot)] == ($past(pwdata_i[15:0]) & cctr_reg_mask($past(slot)))) // [RULE_13]
		else $error("write did not take effect");
	AST_LOAD_STALL: assert property ((q.st == CCTR_ST_LOAD) |-> !pready_o) // [RULE_07]
		else $error("bus answered before fuse load");

	// ---------------------------------------------------------------
	// data path checks
	// ---------------------------------------------------------------
	AST_GAIN_TRIM_CORE2_INPUT_A_PATH: assert property (p_gain(core2a_vld_i, core2a_data_i, q.regs[SLOT_GAIN2][4:0], core2a_data_o)) // [RULE_09]
		else $error("core two input A gain wrong");
	AST_VLD0: assert property (1'b1 |=> core0_vld_o == $past(core0_vld_i)) // [RULE_05]
		else $error("core zero valid lost");
	AST_VLD1: assert property (1'b1 |=> core1_vld_o == $past(core1_vld_i)) // [RULE_06]
		else $error("core one valid lost");
	AST_VLD2: assert property (1'b1 |=> core2a_vld_o == $past(core2a_vld_i)) // [RULE_09]
		else $error("core two valid lost");
	AST_VLD3: assert property (1'b1 |=> core3_vld_o == $past(core3_vld_i)) // [RULE_01]
		else $error("core three valid lost");
	AST_VLD4: assert property (1'b1 |=> core4_vld_o == $past(core4_vld_i)) // [RULE_03]
		else $error("core four valid lost");
	AST_VLD5: assert property (1'b1 |=> core5_vld_o == $past(core5_vld_i)) // [RULE_04]
		else $error("core five valid lost");

	// ---------------------------------------------------------------
	// bus checks
	// ---------------------------------------------------------------
	sequence s_acc;
		psel_i && penable_i && pready_o;
	endsequence

	// an unmapped access must neither answer data nor touch storage
	AST_MISS: assert property (s_acc ##0 !hit |-> pslverr_o && prdata_o == 32'h0) // [RULE_12]
		else $error("unmapped access not refused");
	AST_HIT_OK: assert property (s_acc ##0 hit |-> !pslverr_o) // [RULE_12]
		else $error("mapped access refused");
	AST_MISS_NO_WR: assert property (s_acc ##0 (pwrite_i && !hit) |=> q.regs == $past(q.regs)) // [RULE_12]
		else $error("unmapped write changed storage");
	AST_UPPER: assert property (prdata_o[31:16] == 16'h0) // [RULE_12]
		else $error("read data upper half not zero");
	AST_READY_HOLD: assert property (pready_o |=> pready_o) // [RULE_07]
		else $error("bus ready dropped after load");

	// ---------------------------------------------------------------
	// fuse load checks
	// ---------------------------------------------------------------
	sequence s_fuse_wait;
		fuse_req_o && !fuse_ack_i;
	endsequence

	AST_FUSE_HOLD: assert property (s_fuse_wait |=> $stable(fuse_addr_o)) // [RULE_07]
		else $error("fuse address moved before acknowledge");
	AST_FUSE_ADV: assert property (fuse_req_o && fuse_ack_i && (fuse_addr_o != SLOT_LAST) |=> fuse_addr_o == $past(fuse_addr_o) + 3'h1) // [RULE_07]
		else $error("fuse address did not advance");
	AST_FUSE_DONE: assert property (ld_done |-> !fuse_req_o) // [RULE_07]
		else $error("fuse request after load done");
	// gain slots keep only their five field bits from the fuse word
	AST_GAIN_LOAD: assert property (ld_we && (ld_idx >= SLOT_GAIN_C0) |=> q.regs[$past(ld_idx)][15:5] == 11'h0) // [RULE_07]
		else $error("gain fuse word not masked");

endmodule

//--- verif/cctr_trim_regs_tb.sv
// self-checking bench for the converter core trim register bank
`timescale 1ns/1ns
module cctr_trim_regs_tb;
	import cctr_pkg::*;
	// ----------------------------------------
	// signals
	// ----------------------------------------
	logic        clk_sys_i, rstn_i, psel_i, penable_i, pwrite_i, fuse_ack_i, core3_sel_d_i;
	logic [13:0] paddr_i;
	logic [31:0] pwdata_i, prdata_o, rd;
	logic        pready_o, pslverr_o, fuse_req_o, err;
	logic [2:0]  fuse_addr_o;
	logic [11:0] fuse_data_i, din;
	logic [5:0]  vin;
	logic [11:0] c0_o, c1_o, c2_o, c3_o, c4_o, c5_o;
	logic [5:0]  vo;
	logic [15:0] mdl [7];
	int          n_fail, n_tests;
	localparam logic [11:0] IDX [7] = '{IDX_OFFSET_TRIM_CORE3_INPUT_C, IDX_OFFSET_TRIM_CORE3_INPUT_D,
		IDX_OFFSET_TRIM_CORE4, IDX_OFFSET_TRIM_CORE5, IDX_GAIN_TRIM_CORE0, IDX_GAIN_TRIM_CORE1,
		IDX_GAIN_TRIM_CORE2_INPUT_A};
	localparam logic [15:0] WV [7] = '{16'h0123, 16'h0E00, 16'h0FFF, 16'h0001, 16'h001F, 16'h0010, 16'h0005};

	cctr_trim_regs cctr_trim_regs_i (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .paddr_i(paddr_i),
		.psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .pwdata_i(pwdata_i),
		.prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .fuse_req_o(fuse_req_o),
		.fuse_addr_o(fuse_addr_o), .fuse_data_i(fuse_data_i), .fuse_ack_i(fuse_ack_i),
		.core0_data_i(din), .core0_vld_i(vin[0]), .core1_data_i(din), .core1_vld_i(vin[1]),
		.core2a_data_i(din), .core2a_vld_i(vin[2]), .core3_data_i(din), .core3_vld_i(vin[3]),
		.core3_sel_d_i(core3_sel_d_i), .core4_data_i(din), .core4_vld_i(vin[4]),
		.core5_data_i(din), .core5_vld_i(vin[5]), .core0_data_o(c0_o), .core0_vld_o(vo[0]),
		.core1_data_o(c1_o), .core1_vld_o(vo[1]), .core2a_data_o(c2_o), .core2a_vld_o(vo[2]),
		.core3_data_o(c3_o), .core3_vld_o(vo[3]), .core4_data_o(c4_o), .core4_vld_o(vo[4]),
		.core5_data_o(c5_o), .core5_vld_o(vo[5]));

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [11:0] fv(input logic [2:0] a);
		return {a, a, a, a} ^ 12'h5A3;
	endfunction

	function automatic logic [31:0] e_ofs(input logic [11:0] d, input logic [15:0] r);
		logic [12:0] s;
		s = {1'b0, d} + {1'b0, r[11:0]};
		return s[12] ? 32'(SAT_MAX) : 32'(s[11:0]);
	endfunction

	function automatic logic [31:0] e_gain(input logic [11:0] d, input logic [15:0] r);
		logic [17:0] p;
		logic [12:0] s;
		p = d * r[4:0];
		s = {1'b0, d} + 13'(p >> GAIN_SHIFT);
		return s[12] ? 32'(SAT_MAX) : 32'(s[11:0]);
	endfunction

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// master holds the request until pready is seen high at a rising edge
	task automatic apb(input logic wr, input logic [13:0] a, input logic [31:0] wd);
		psel_i    <= 1'b1;
		penable_i <= 1'b0;
		paddr_i   <= a;
		pwrite_i  <= wr;
		pwdata_i  <= wd;
		@(posedge clk_sys_i);
		penable_i <= 1'b1;
		do @(posedge clk_sys_i); while (pready_o !== 1'b1);
		rd = prdata_o;
		err = pslverr_o;
		psel_i    <= 1'b0;
		penable_i <= 1'b0;
		@(posedge clk_sys_i);
	endtask

	// one sample on every core, judged one cycle later
	task automatic smp(input logic [11:0] d, input logic sel);
		din           <= d;
		vin           <= 6'h3F;
		core3_sel_d_i <= sel;
		@(posedge clk_sys_i);
		vin <= 6'h00;
		#1;
		chk(32'(vo), 32'h3F);
		chk(32'(c0_o), e_gain(d, mdl[4]));
		chk(32'(c1_o), e_gain(d, mdl[5]));
		chk(32'(c2_o), e_gain(d, mdl[6]));
		chk(32'(c3_o), e_ofs(d, mdl[sel]));
		chk(32'(c4_o), e_ofs(d, mdl[2]));
		chk(32'(c5_o), e_ofs(d, mdl[3]));
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_fuse();
		for (int i = 0; i < 7; i++) begin
			mdl[i] = (i < 4) ? 16'(fv(3'(i))) : 16'(fv(3'(i))) & GAIN_FIELD_MASK;
			apb(1'b0, {IDX[i], 2'b00}, 32'h0);
			chk(rd, 32'(mdl[i]));
		end
		smp(12'h0F0, 1'b0);
	endtask

	task automatic t_rw();
		// no offset calibration runs in this bench, so offset access is always allowed
		for (int i = 0; i < 7; i++) begin
			apb(1'b1, {IDX[i], 2'b00}, 32'(WV[i]));
			mdl[i] = WV[i];
		end
		for (int i = 0; i < 7; i++) begin
			apb(1'b0, {IDX[i], 2'b00}, 32'h0);
			chk(rd, 32'(mdl[i]));
			chk(32'(err), 32'h0);
		end
	endtask

	task automatic t_err();
		apb(1'b1, 14'hCE4, 32'h0000_0ABC);
		chk(32'(err), 32'h1);
		apb(1'b0, 14'hCE1, 32'h0);
		chk(rd, 32'h0);
		chk(32'(err), 32'h1);
		apb(1'b0, {IDX[0], 2'b00}, 32'h0);
		chk(rd, 32'(mdl[0]));
	endtask

	task automatic t_path();
		smp(12'h800, 1'b0);
		smp(12'h800, 1'b1);
		smp(12'hFFF, 1'b0);
		smp(12'h000, 1'b1);
		@(posedge clk_sys_i);
		apb(1'b1, {IDX[2], 2'b00}, 32'h0000_0010);
		mdl[2] = 16'h0010;
		smp(12'h800, 1'b1);
	endtask

	task automatic finish_test();
		if (n_fail == 0 && n_tests > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// ----------------------------------------
	// clock, fuse responder, watchdog, main
	// ----------------------------------------
	initial begin
		clk_sys_i = 1'b0;
		forever #10 clk_sys_i = ~clk_sys_i;
	end

	// acknowledge every other cycle so the word always matches the held address
	always @(posedge clk_sys_i) begin
		fuse_ack_i  <= fuse_req_o && !fuse_ack_i && rstn_i;
		fuse_data_i <= fv(fuse_addr_o);
	end

	initial begin
		repeat (3000) @(posedge clk_sys_i);
		n_fail++;
		finish_test();
	end

	initial begin
		n_fail = 0;
		n_tests = 0;
		rstn_i = 1'b0;
		{psel_i, penable_i, pwrite_i, fuse_ack_i, core3_sel_d_i} = 5'h00;
		paddr_i = 14'h0000;
		pwdata_i = 32'h0;
		fuse_data_i = 12'h000;
		din = 12'h000;
		vin = 6'h00;
		repeat (2) @(posedge clk_sys_i);
		#1;
		chk(32'(pready_o), 32'h0);
		@(posedge clk_sys_i);
		rstn_i <= 1'b1;
		@(posedge clk_sys_i);
		t_fuse();
		t_rw();
		t_err();
		t_path();
		finish_test();
	end
endmodule
